// ### verilog/pwmpac_pkg.sv
// Shared constants for the prescaler, alignment and pairing control block
package pwmpac_pkg;
    localparam int          ADDR_W          = 8;
    localparam int          DATA_W          = 8;
    localparam int          NUM_CH          = 8;
    localparam int          NUM_PAIR        = 4;
    localparam int          PRE_W           = 7;

    // Register offsets
    localparam logic [7:0]  OFF_PRESCALE    = 8'h03;
    localparam logic [7:0]  OFF_ALIGN       = 8'h04;
    localparam logic [7:0]  OFF_CONTROL     = 8'h05;

    // Reset values
    localparam logic [7:0]  RST_PRESCALE    = 8'h00;
    localparam logic [7:0]  RST_ALIGN       = 8'h00;
    localparam logic [7:0]  RST_CONTROL     = 8'h00;

    // Implemented bits; the rest read as zero
    localparam logic [7:0]  MASK_PRESCALE   = 8'h77;
    localparam logic [7:0]  MASK_ALIGN      = 8'hFF;
    localparam logic [7:0]  MASK_CONTROL    = 8'hFC;

    // Field positions
    localparam int          POS_CLK_A       = 0;
    localparam int          POS_CLK_B       = 4;
    localparam int          POS_JOIN        = 4;
    localparam int          POS_WAIT_STOP   = 3;
    localparam int          POS_FREEZE_STOP = 2;

    // Largest prescale divisor
    localparam int          MAX_DIVISOR     = 128;
endpackage : pwmpac_pkg

// ### verilog/pwmpac_if.sv
// Carriers between the control top and its prescaler and comparator
`timescale 1ns/100ps
interface pwmpac_pre_if;
    logic       run;
    logic [2:0] sel_a;
    logic [2:0] sel_b;
    logic       tick_a;
    logic       tick_b;
    modport ctrl (output run, output sel_a, output sel_b, input tick_a, input tick_b);
    modport pre  (input run, input sel_a, input sel_b, output tick_a, output tick_b);
endinterface : pwmpac_pre_if

interface pwmpac_cmp_if;
    logic [63:0] cnt;
    logic [63:0] per;
    logic [63:0] dty;
    logic [3:0]  join_pair;
    logic [7:0]  per_hit;
    logic [7:0]  dty_hit;
    modport ctrl (output cnt, output per, output dty, output join_pair,
                  input per_hit, input dty_hit);
    modport cmp  (input cnt, input per, input dty, input join_pair,
                  output per_hit, output dty_hit);
endinterface : pwmpac_cmp_if

// ### verilog/pwmpac_prescaler.sv
// Free-running prescale counter giving single-cycle clock A and clock B enables
`timescale 1ns/100ps
module pwmpac_prescaler (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rstn_in,
    // Control side
    pwmpac_pre_if.pre pre
);
    typedef struct packed {
        logic [pwmpac_pkg::PRE_W-1:0] cnt;
        logic                         tick_a;
        logic                         tick_b;
    } pwmpac_pre_t;

    pwmpac_pre_t st;
    pwmpac_pre_t next_st;

    // Low bits that must all be one for a tick at divisor 2**sel
    function automatic logic [pwmpac_pkg::PRE_W-1:0] div_mask(input logic [2:0] sel);
        logic [7:0] one_hot;
        one_hot  = 8'h01 << sel;
        div_mask = 7'(one_hot - 8'h01);
    endfunction : div_mask

    always_comb begin
        next_st        = st;
        next_st.tick_a = 1'b0;
        next_st.tick_b = 1'b0;
        // Stopped input clock holds the count so counting resumes where it left
        if (pre.run) begin
            next_st.cnt    = 7'(st.cnt + 7'h01);
            // New selects apply at once; a glitchy first pulse is accepted
            next_st.tick_a = (st.cnt & div_mask(pre.sel_a)) == div_mask(pre.sel_a);
            next_st.tick_b = (st.cnt & div_mask(pre.sel_b)) == div_mask(pre.sel_b);
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign pre.tick_a = st.tick_a;
    assign pre.tick_b = st.tick_b;
endmodule : pwmpac_prescaler

// ### verilog/pwmpac_compare.sv
// Counter, period and duty equality in 8-bit or joined 16-bit form
`timescale 1ns/100ps
module pwmpac_compare (
    // Clock and reset
    input  wire logic ref_clk_in,
    input  wire logic rstn_in,
    // Control side
    pwmpac_cmp_if.cmp cmp
);
    typedef struct packed {
        logic [7:0] per_hit;
        logic [7:0] dty_hit;
    } pwmpac_cmp_t;

    pwmpac_cmp_t st;
    pwmpac_cmp_t next_st;

    function automatic logic [7:0] byte_of(input logic [63:0] v, input int ch);
        byte_of = v[ch*8 +: 8];
    endfunction : byte_of

    always_comb begin
        next_st = '0;
        for (int p = 0; p < pwmpac_pkg::NUM_PAIR; p++) begin
            if (cmp.join_pair[p]) begin
                // Even channel is the high byte; result shows on the odd one
                next_st.per_hit[2*p+1] =
                    {byte_of(cmp.cnt, 2*p), byte_of(cmp.cnt, 2*p+1)} ==
                    {byte_of(cmp.per, 2*p), byte_of(cmp.per, 2*p+1)};
                next_st.dty_hit[2*p+1] =
                    {byte_of(cmp.cnt, 2*p), byte_of(cmp.cnt, 2*p+1)} ==
                    {byte_of(cmp.dty, 2*p), byte_of(cmp.dty, 2*p+1)};
            end else begin
                for (int k = 0; k < 2; k++) begin
                    next_st.per_hit[2*p+k] = byte_of(cmp.cnt, 2*p+k) == byte_of(cmp.per, 2*p+k);
                    next_st.dty_hit[2*p+k] = byte_of(cmp.cnt, 2*p+k) == byte_of(cmp.dty, 2*p+k);
                end
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign cmp.per_hit = st.per_hit;
    assign cmp.dty_hit = st.dty_hit;
endmodule : pwmpac_compare

// ### verilog/pwmpac_ctrl.sv
// Prescale, alignment and pairing control of an eight-channel 8-bit modulator
// Contract
// - Clock B is bus clock over 2**field
// - Clock A is bus clock over 2**field
// - Clock B to channels 2,3,6,7; A others
// - Prescale writes take effect immediately, unprotected
// - Alignment bit one gives center, zero left
// - Bit 7 joins channels 6 and 7
// - Bit 6 joins channels 4 and 5
// - Bit 5 joins channels 2 and 3
// - Bit 4 joins channels 0 and 1
// - Odd channel's pin and controls govern pair
// - Wait-stop bit halts prescaler in wait mode
// - Freeze-stop bit halts prescaler in freeze
// - Registers stay reachable; resume keeps held counts
// - All three registers readable, writable anytime
// - Joined even channel enable ignored, output off
// - Per-channel select of plain or scaled clock
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps
module pwmpac_ctrl (
    // Clock and reset
    input  wire logic        ref_clk_in,
    input  wire logic        rstn_in,
    // Register port
    input  wire logic [7:0]  addr_in,
    input  wire logic [7:0]  wdata_in,
    input  wire logic        wr_in,
    input  wire logic        rd_in,
    output logic      [7:0]  rdata_out,
    // Operating modes
    input  wire logic        wait_mode_in,
    input  wire logic        freeze_mode_in,
    // Channel controls held elsewhere
    input  wire logic [7:0]  channel_enable_bits_in,
    input  wire logic [7:0]  channel_clock_select_bit_in,
    input  wire logic        scaled_a_tick_in,
    input  wire logic        scaled_b_tick_in,
    // Channel counter, period and duty bytes
    input  wire logic [63:0] counter_bytes_in,
    input  wire logic [63:0] period_bytes_in,
    input  wire logic [63:0] duty_bytes_in,
    // Prescaled clocks
    output logic             clock_a_tick_out,
    output logic             clock_b_tick_out,
    // Per-channel controls
    output logic      [7:0]  channel_tick_out,
    output logic      [7:0]  channel_run_out,
    output logic      [7:0]  center_align_out,
    output logic      [3:0]  pair_join_out,
    // Comparison results
    output logic      [7:0]  period_match_out,
    output logic      [7:0]  duty_match_out
);
    typedef struct packed {
        logic [7:0] prescale_clock_select;
        logic [7:0] center_align_enable;
        logic [7:0] pwm_control;
        logic [7:0] rdata;
        logic [7:0] chan_tick;
        logic [7:0] chan_run;
        logic [7:0] chan_align;
    } pwmpac_ctrl_t;

    pwmpac_ctrl_t st;
    pwmpac_ctrl_t next_st;

    pwmpac_pre_if pre_bus ();
    pwmpac_cmp_if cmp_bus ();

    logic [3:0] join_bits;
    logic [2:0] gov;
    logic       on_b;
    logic       joined;

    // Channel whose controls drive channel ch
    function automatic logic [2:0] governor(input logic [2:0] ch, input logic [3:0] joins);
        governor = joins[ch[2:1]] ? {ch[2:1], 1'b1} : ch;
    endfunction : governor

    assign join_bits = st.pwm_control[pwmpac_pkg::POS_JOIN +: 4];

    // Wait and freeze stop only the prescaler input; registers keep working
    assign pre_bus.run =
        !(wait_mode_in && st.pwm_control[pwmpac_pkg::POS_WAIT_STOP]) &&
        !(freeze_mode_in && st.pwm_control[pwmpac_pkg::POS_FREEZE_STOP]);
    assign pre_bus.sel_a = st.prescale_clock_select[pwmpac_pkg::POS_CLK_A +: 3];
    assign pre_bus.sel_b = st.prescale_clock_select[pwmpac_pkg::POS_CLK_B +: 3];

    assign cmp_bus.cnt       = counter_bytes_in;
    assign cmp_bus.per       = period_bytes_in;
    assign cmp_bus.dty       = duty_bytes_in;
    assign cmp_bus.join_pair = join_bits;

    pwmpac_prescaler u_pre (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .pre        (pre_bus.pre)
    );

    pwmpac_compare u_cmp (
        .ref_clk_in (ref_clk_in),
        .rstn_in    (rstn_in),
        .cmp        (cmp_bus.cmp)
    );

    always_comb begin
        next_st       = st;
        next_st.rdata = 8'h00;
        gov           = 3'h0;
        on_b          = 1'b0;
        joined        = 1'b0;

        // Writes are accepted in every mode, including wait and freeze
        if (wr_in) begin
            unique case (addr_in)
                pwmpac_pkg::OFF_PRESCALE:
                    next_st.prescale_clock_select = wdata_in & pwmpac_pkg::MASK_PRESCALE;
                pwmpac_pkg::OFF_ALIGN:
                    next_st.center_align_enable = wdata_in & pwmpac_pkg::MASK_ALIGN;
                pwmpac_pkg::OFF_CONTROL:
                    next_st.pwm_control = wdata_in & pwmpac_pkg::MASK_CONTROL;
                default: ;
            endcase
        end

        // Read data stand for exactly one cycle; unmapped reads give zero
        if (rd_in) begin
            unique case (addr_in)
                pwmpac_pkg::OFF_PRESCALE: next_st.rdata = st.prescale_clock_select;
                pwmpac_pkg::OFF_ALIGN:    next_st.rdata = st.center_align_enable;
                pwmpac_pkg::OFF_CONTROL:  next_st.rdata = st.pwm_control;
                default:                  next_st.rdata = 8'h00;
            endcase
        end

        for (int i = 0; i < pwmpac_pkg::NUM_CH; i++) begin
            gov    = governor(3'(i), join_bits);
            on_b   = gov[1];
            joined = join_bits[gov[2:1]] && (gov != 3'(i));
            if (channel_clock_select_bit_in[gov]) begin
                next_st.chan_tick[i] = on_b ? scaled_b_tick_in : scaled_a_tick_in;
            end else begin
                next_st.chan_tick[i] = on_b ? pre_bus.tick_b : pre_bus.tick_a;
            end
            // Joined even channel is silenced whatever its own enable says
            next_st.chan_run[i]   = channel_enable_bits_in[gov] && !joined;
            next_st.chan_align[i] = st.center_align_enable[gov];
            if (joined) begin
                next_st.chan_tick[i] = 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            st                       <= '0;
            st.prescale_clock_select <= pwmpac_pkg::RST_PRESCALE;
            st.center_align_enable   <= pwmpac_pkg::RST_ALIGN;
            st.pwm_control           <= pwmpac_pkg::RST_CONTROL;
        end else begin
            st <= next_st;
        end
    end

    assign rdata_out        = st.rdata;
    assign clock_a_tick_out = pre_bus.tick_a;
    assign clock_b_tick_out = pre_bus.tick_b;
    assign channel_tick_out = st.chan_tick;
    assign channel_run_out  = st.chan_run;
    assign center_align_out = st.chan_align;
    assign pair_join_out    = join_bits;
    assign period_match_out = cmp_bus.per_hit;
    assign duty_match_out   = cmp_bus.dty_hit;
endmodule : pwmpac_ctrl

// ### tb/pwmpac_ctrl_sva.sv
// Assertion checker for the prescale, alignment and pairing control block
`timescale 1ns/100ps
module pwmpac_ctrl_sva (
    // Clock, reset and register port
    input wire logic       ref_clk_in,
    input wire logic       rstn_in,
    input wire logic [7:0] addr_in,
    input wire logic [7:0] wdata_in,
    input wire logic       wr_in,
    input wire logic       rd_in,
    input wire logic [7:0] rdata_out,
    // Modes and channel controls
    input wire logic       wait_mode_in,
    input wire logic       freeze_mode_in,
    input wire logic [7:0] channel_enable_bits_in,
    input wire logic [7:0] channel_clock_select_bit_in,
    input wire logic       scaled_a_tick_in,
    input wire logic       scaled_b_tick_in,
    // Block outputs
    input wire logic       clock_a_tick_out,
    input wire logic       clock_b_tick_out,
    input wire logic [7:0] channel_tick_out,
    input wire logic [7:0] channel_run_out,
    input wire logic [3:0] pair_join_out
);
    logic [3:2] stop_bits;
    logic       stop;
    assign stop = (wait_mode_in & stop_bits[3]) | (freeze_mode_in & stop_bits[2]);
    // Shadow of the stop bits, fed by the same writes the block sees
    always_ff @(posedge ref_clk_in or negedge rstn_in) begin
        if (!rstn_in) begin
            stop_bits <= 2'h0;
        end else if (wr_in && addr_in == pwmpac_pkg::OFF_CONTROL) begin
            stop_bits <= wdata_in[3:2];
        end
    end
    default clocking cb @(posedge ref_clk_in); endclocking
    default disable iff (!rstn_in);
    sequence s_wr_ctl;
        wr_in && addr_in == pwmpac_pkg::OFF_CONTROL;
    endsequence
    sequence s_rd_ctl;
        rd_in && addr_in == pwmpac_pkg::OFF_CONTROL;
    endsequence
    property p_rd_idle;
        !$past(rd_in) |-> rdata_out == 8'h00;
    endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("read data not zero");
    property p_ctl_back;
        s_wr_ctl ##1 s_rd_ctl |=> rdata_out == ($past(wdata_in, 2) & pwmpac_pkg::MASK_CONTROL);
    endproperty
    a_ctl_back: assert property (p_ctl_back) else $error("control readback wrong");
    property p_join;
        s_wr_ctl |=> pair_join_out == $past(wdata_in[7:4]);
    endproperty
    a_join: assert property (p_join) else $error("pair join wrong");
    property p_even_off;
        $past(pair_join_out[3]) |-> !channel_run_out[6] && !channel_tick_out[6];
    endproperty
    a_even_off: assert property (p_even_off) else $error("joined even channel active");
    property p_run_gov;
        $past(rstn_in) |-> channel_run_out[1:0] == ($past(pair_join_out[0]) ?
            {$past(channel_enable_bits_in[1]), 1'b0} : $past(channel_enable_bits_in[1:0]));
    endproperty
    a_run_gov: assert property (p_run_gov) else $error("channel run wrong");
    property p_tick_a;
        $past(rstn_in) |-> channel_tick_out[1] == ($past(channel_clock_select_bit_in[1]) ?
            $past(scaled_a_tick_in) : $past(clock_a_tick_out));
    endproperty
    a_tick_a: assert property (p_tick_a) else $error("channel clock A wrong");
    property p_tick_b;
        $past(rstn_in) |-> channel_tick_out[7] == ($past(channel_clock_select_bit_in[7]) ?
            $past(scaled_b_tick_in) : $past(clock_b_tick_out));
    endproperty
    a_tick_b: assert property (p_tick_b) else $error("channel clock B wrong");
    // Three cycles leave room for a tick already in the output flop
    property p_stop;
        stop [*3] |-> !clock_a_tick_out && !clock_b_tick_out;
    endproperty
    a_stop: assert property (p_stop) else $error("tick while stopped");
endmodule : pwmpac_ctrl_sva
bind pwmpac_ctrl pwmpac_ctrl_sva i_sva (.*);

// ### tb/pwmpac_ctrl_tb.sv
// Self-checking bench for the prescale, alignment and pairing control block
`timescale 1ns/100ps
module pwmpac_ctrl_tb;
    logic        ref_clk_in = 1'b0, rstn_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic        wait_mode_in = 1'b0, freeze_mode_in = 1'b0;
    logic        scaled_a_tick_in = 1'b0, scaled_b_tick_in = 1'b0;
    logic [7:0]  addr_in = 8'h00, wdata_in = 8'h00;
    logic [7:0]  channel_enable_bits_in = 8'h00, channel_clock_select_bit_in = 8'h00;
    logic [63:0] counter_bytes_in = 64'h0, period_bytes_in = 64'h0, duty_bytes_in = 64'h0;
    logic [7:0]  rdata_out, channel_tick_out, channel_run_out, center_align_out;
    logic [7:0]  period_match_out, duty_match_out;
    logic [3:0]  pair_join_out;
    logic        clock_a_tick_out, clock_b_tick_out;
    int          n_errors = 0, n_tests = 0;
    always #4 ref_clk_in = ~ref_clk_in;
    always @(posedge ref_clk_in) begin
        scaled_a_tick_in <= 1'($urandom);
        scaled_b_tick_in <= 1'($urandom);
    end
    pwmpac_ctrl i_dut (.*);
    task automatic chk(string nm, logic [7:0] seen, logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic wr(logic [7:0] a, logic [7:0] d);
        addr_in <= a;
        wdata_in <= d;
        wr_in <= 1'b1;
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
        // Step off the edge so a following request never reassigns the strobe here
        #1;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        // Read data stand only until the next edge
        #1 chk("rdata", rdata_out, e);
    endtask : rd
    task automatic ticks(output int ca, output int cb);
        ca = 0;
        cb = 0;
        repeat (128) begin
            @(posedge ref_clk_in);
            #1 ca += int'(clock_a_tick_out);
            cb += int'(clock_b_tick_out);
        end
    endtask : ticks
    // A joined even channel takes its controls from the odd partner
    function automatic logic [7:0] gov(logic [7:0] v, logic [3:0] j);
        for (int n = 0; n < 8; n++) gov[n] = (n % 2 == 0 && j[n/2]) ? v[n|1] : v[n];
    endfunction : gov
    function automatic logic [7:0] mt(logic [63:0] a, logic [63:0] b, logic [3:0] j);
        logic e0, e1;
        for (int k = 0; k < 4; k++) begin
            e0 = a[16*k +: 8] == b[16*k +: 8];
            e1 = a[16*k+8 +: 8] == b[16*k+8 +: 8];
            mt[2*k] = e0 & !j[k];
            mt[2*k+1] = j[k] ? e0 & e1 : e1;
        end
    endfunction : mt
    task automatic complete_run();
        $display("checks %0d mismatches %0d", n_tests, n_errors);
        if (n_errors == 0 && n_tests > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (8000) @(posedge ref_clk_in);
        n_errors++;
        complete_run();
    end
    initial begin
        logic [7:0]  sh [3];
        logic [7:0]  a, b, d, jv;
        logic [63:0] c, p, q;
        int          ca, cb;
        void'($urandom(87));
        sh = '{default: 8'h00};
        repeat (8) @(posedge ref_clk_in);
        rstn_in <= 1'b1;
        @(posedge ref_clk_in);
        for (int i = 2; i < 7; i++) rd(8'(i), 8'h00);
        wr(8'h05, 8'hFF);
        rd(8'h05, 8'hFC);
        sh[2] = 8'hFC;
        repeat (30) begin
            a = 8'(2 + $urandom_range(4));
            b = 8'(2 + $urandom_range(4));
            d = 8'($urandom);
            wr(a, d);
            if (a == 3) sh[0] = d & 8'h77;
            if (a == 4) sh[1] = d;
            if (a == 5) sh[2] = d & 8'hFC;
            rd(b, (b inside {[3:5]}) ? sh[b-3] : 8'h00);
        end
        $display("register test done");
        wr(8'h05, 8'h00);
        for (int s = 0; s < 8; s++) begin
            wr(8'h03, 8'(((7 - s) << 4) | s));
            repeat (4) @(posedge ref_clk_in);
            ticks(ca, cb);
            chk("clock_a_ticks", 8'(ca), 8'(128 >> s));
            chk("clock_b_ticks", 8'(cb), 8'(128 >> (7 - s)));
        end
        $display("prescale test done");
        wr(8'h03, 8'h00);
        for (int m = 0; m < 4; m++) begin
            d = (m[0] ^ m[1]) ? 8'h08 : 8'h04;
            wr(8'h05, d);
            wait_mode_in <= !m[0];
            freeze_mode_in <= m[0];
            repeat (3) @(posedge ref_clk_in);
            ticks(ca, cb);
            chk("held_a_ticks", 8'(ca), m[1] ? 8'h00 : 8'h80);
            chk("held_b_ticks", 8'(cb), m[1] ? 8'h00 : 8'h80);
            rd(8'h05, d);
            wr(8'h05, 8'h00);
            repeat (3) @(posedge ref_clk_in);
            ticks(ca, cb);
            chk("resumed_a_ticks", 8'(ca), 8'h80);
            chk("resumed_b_ticks", 8'(cb), 8'h80);
            wait_mode_in <= 1'b0;
            freeze_mode_in <= 1'b0;
        end
        $display("stop test done");
        for (int i = 0; i < 24; i++) begin
            jv = i == 0 ? 8'hF0 : i == 1 ? 8'h00 : 8'($urandom) & 8'hF0;
            d = 8'($urandom);
            c = {$urandom, $urandom};
            p = c;
            q = c;
            for (int k = 0; k < 8; k++) begin
                if (i > 1 && $urandom_range(1) == 1) p[8*k +: 8] = 8'($urandom);
                if (i > 1 && $urandom_range(1) == 1) q[8*k +: 8] = 8'($urandom);
            end
            channel_enable_bits_in <= 8'h00;
            wr(8'h03, 8'($urandom) & 8'h77);
            wr(8'h05, jv);
            wr(8'h04, d);
            channel_enable_bits_in <= 8'($urandom);
            channel_clock_select_bit_in <= 8'($urandom);
            counter_bytes_in <= c;
            period_bytes_in <= p;
            duty_bytes_in <= q;
            repeat (3) @(posedge ref_clk_in);
            #1 chk("pair_join", 8'(pair_join_out), 8'(jv[7:4]));
            chk("align", center_align_out, gov(d, jv[7:4]));
            chk("run", channel_run_out, gov(channel_enable_bits_in, jv[7:4]) &
                ~{1'b0, jv[7], 1'b0, jv[6], 1'b0, jv[5], 1'b0, jv[4]});
            chk("period_match", period_match_out, mt(c, p, jv[7:4]));
            chk("duty_match", duty_match_out, mt(c, q, jv[7:4]));
        end
        $display("pairing test done");
        complete_run();
    end
endmodule : pwmpac_ctrl_tb
